// ==== verilog/mcw_consts.vh ====
// constants for the modbus communication watchdog
`ifndef MCW_CONSTS_VH
`define MCW_CONSTS_VH
// register addresses
`define MCW_ADDR_COMMAND 16'hFA00
`define MCW_ADDR_TIMEOUT 16'hFA01
`define MCW_ADDR_STATE 16'hFA02
`define MCW_ADDR_CONFIG 16'hFA03
// command codes
`define MCW_CMD_START 16'h5555
`define MCW_CMD_STOP 16'h55AA
`define MCW_CMD_RESET 16'hAAAA
// state codes as read back
`define MCW_ST_UNSET 16'hFFFF
`define MCW_ST_STOPPED 16'h0000
`define MCW_ST_RUNNING 16'h0001
`define MCW_ST_EXPIRED 16'h0002
// exception codes
`define MCW_EXC_NONE 8'h00
`define MCW_EXC_ILLEGAL_FUNCTION 8'h01
`define MCW_EXC_ILLEGAL_ADDRESS 8'h02
`define MCW_EXC_ILLEGAL_VALUE 8'h03
// config bit positions and reset value
`define MCW_CFG_EXPLICIT 0
`define MCW_CFG_STATUS_TRIG 1
`define MCW_CFG_DROP_LINKS 2
`define MCW_CFG_SIMPLE 7
`define MCW_CFG_RESET 8'h04
`define MCW_CFG_MASK 8'h87
// timing
`define MCW_CLK_HZ 25000000
`define MCW_TICK_MS 1
`define MCW_TICK_CYCLES ((`MCW_CLK_HZ / 1000) * `MCW_TICK_MS)
`define MCW_TIMEOUT_RESET 16'h0000
`endif

// ==== verilog/mcw_watchdog.v ====
// modbus communication watchdog with its command, timeout, state and config registers
`timescale 1ns/1ps
`include "mcw_consts.vh"
// What this block does
// - every valid master request except a status access counts as a trigger, unless options say otherwise.
// - running with no trigger for the timeout interval moves to expired.
// - config bit 7 picks advanced (command) or simple (auto-armed) mode.
// - simple mode keeps the watchdog active whenever timeout exceeds zero.
// - simple mode accepts only the start command, as a trigger.
// - simple mode cannot be stopped except by returning to advanced mode.
// - the command register is write-only and never reads back.
// - start fails with 0x03 if unset or expired-advanced, else restarts running.
// - stop fails with 0x03 if unset, expired-advanced or simple, else stops.
// - repeated stop while stopped is accepted silently.
// - reset moves expired-advanced to stopped, otherwise answers 0x03.
// - timeout counts in 1 ms units, unsigned up to 65535.
// - timeout resets to zero; zero keeps the watchdog unset, refusing start.
// - timeout writable only when unset or stopped, else exception 0x01.
// - state reads 0xFFFF unset, 0 stopped, 1 running, 2 expired.
// - only writing a nonzero timeout leaves the unset state.
// - simple mode never shows the stopped state.
// - simple mode restarts an expired watchdog on the next trigger.
// - config decides explicit-trigger and whether status reads trigger.
// - config can select dropping all tcp links on expiry.
// - explicit-trigger counts only a start write to the command register, plus status reads when the status-trigger bit is set.
// - status-trigger bit set makes status reads retrigger; clear, they do not.
// - drop-links bit set (default) drops all links on entering expired.
// - simple mode arms once timeout nonzero; each trigger restarts it.
module mcw_watchdog #(
    parameter TICK_CYCLES = `MCW_TICK_CYCLES
)
(
    // clock and reset
    input wire clk,
    input wire arst_n,
    // register request from the modbus slave, one cycle strobe per register access
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    // answer, one cycle after the request
    output reg rsp_valid,
    output reg [15:0] rsp_rdata,
    output reg [7:0] rsp_exception,
    // other valid modbus traffic that is not a register access of this block
    input wire other_req,
    // expiry action and state
    output reg drop_links_on_expiry,
    output reg [15:0] wd_state_out
);

    // ----------------------------------------------------------------
    // states
    // ----------------------------------------------------------------
    // one-hot codes; the status word that the master reads is decoded from them
    localparam [3:0] ST_UNSET = 4'h1;
    localparam [3:0] ST_STOPPED = 4'h2;
    localparam [3:0] ST_RUNNING = 4'h4;
    localparam [3:0] ST_EXPIRED = 4'h8;

    // ----------------------------------------------------------------
    // reset release
    // ----------------------------------------------------------------
    reg rst_sync1;
    reg rst_sync2;

    // release is synchronised so that no flop leaves reset on a partial edge
    always @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            rst_sync1 <= 1'b0;
            rst_sync2 <= 1'b0;
        end
        else
        begin
            rst_sync1 <= 1'b1;
            rst_sync2 <= rst_sync1;
        end
    end

    wire rst_n = rst_sync2;

    // ----------------------------------------------------------------
    // registers and request decode
    // ----------------------------------------------------------------
    reg [3:0] state;
    reg [15:0] wd_timeout_ms;
    reg [7:0] wd_config;
    reg [15:0] remain;
    reg [24:0] tick_cnt;
    reg tick;

    // configuration fields
    wire simple = wd_config[`MCW_CFG_SIMPLE];
    wire explicit = wd_config[`MCW_CFG_EXPLICIT];
    wire stat_trig = wd_config[`MCW_CFG_STATUS_TRIG];
    wire active = (state == ST_RUNNING) || (state == ST_EXPIRED);

    // address decode of the four registers; any other address is refused
    wire acc_cmd = req_valid && (req_addr == `MCW_ADDR_COMMAND);
    wire acc_tmo = req_valid && (req_addr == `MCW_ADDR_TIMEOUT);
    wire acc_sts = req_valid && (req_addr == `MCW_ADDR_STATE);
    wire acc_cfg = req_valid && (req_addr == `MCW_ADDR_CONFIG);
    wire acc_bad = req_valid && !acc_cmd && !acc_tmo && !acc_sts && !acc_cfg;
    wire start_wr = acc_cmd && req_write && (req_wdata == `MCW_CMD_START);

    // trigger qualification; an access that this block refuses still reached the slave
    // status accesses are left out by default, so a master that only polls the state
    // cannot keep the watchdog alive without meaning to
    reg trig;
    always @*
    begin
        if (explicit)
            trig = start_wr;
        else
            trig = other_req || (req_valid && !acc_sts);
        if (acc_sts && !req_write && stat_trig)
            trig = 1'b1;
    end

    // ----------------------------------------------------------------
    // register access and state machine
    // ----------------------------------------------------------------
    // next values of the registers and of the answer
    reg [3:0] next_state;
    reg [15:0] next_timeout;
    reg [7:0] next_config;
    reg [7:0] next_exc;
    reg [15:0] next_rdata;
    reg next_reload;

    // one register access per cycle; a refused access leaves the state alone unless, as a trigger, it revives an expired simple-mode watchdog
    always @*
    begin
        next_state = state;
        next_timeout = wd_timeout_ms;
        next_config = wd_config;
        next_exc = `MCW_EXC_NONE;
        next_rdata = 16'h0000;
        next_reload = 1'b0;
        // command register: write-only, each code judged against state and mode
        if (acc_cmd)
        begin
            if (!req_write)
                next_exc = `MCW_EXC_ILLEGAL_FUNCTION;
            else if (req_wdata == `MCW_CMD_START)
            begin
                if (state == ST_UNSET || (state == ST_EXPIRED && !simple))
                    next_exc = `MCW_EXC_ILLEGAL_VALUE;
                else
                begin
                    next_state = ST_RUNNING;
                    next_reload = 1'b1;
                end
            end
            else if (req_wdata == `MCW_CMD_STOP)
            begin
                if (state == ST_UNSET || simple || state == ST_EXPIRED)
                    next_exc = `MCW_EXC_ILLEGAL_VALUE;
                else
                    next_state = ST_STOPPED;
            end
            else if (req_wdata == `MCW_CMD_RESET)
            begin
                if (state == ST_EXPIRED && !simple)
                    next_state = ST_STOPPED;
                else
                    next_exc = `MCW_EXC_ILLEGAL_VALUE;
            end
            else
                next_exc = `MCW_EXC_ILLEGAL_VALUE;
        end
        // timeout register: frozen while the watchdog is active
        else if (acc_tmo)
        begin
            next_rdata = wd_timeout_ms;
            if (req_write)
            begin
                if (active)
                    next_exc = `MCW_EXC_ILLEGAL_FUNCTION;
                else
                begin
                    next_timeout = req_wdata;
                    if (req_wdata == 16'h0000)
                        next_state = ST_UNSET;
                    else if (simple)
                    begin
                        next_state = ST_RUNNING;
                        next_reload = 1'b1;
                    end
                    else
                        next_state = ST_STOPPED;
                end
            end
        end
        // status register: read-only
        else if (acc_sts)
        begin
            if (req_write)
                next_exc = `MCW_EXC_ILLEGAL_FUNCTION;
            else
                next_rdata = wd_state_out;
        end
        // config register: free in simple mode, frozen while active in advanced mode
        else if (acc_cfg)
        begin
            next_rdata = {8'h00, wd_config};
            if (req_write)
            begin
                if (active && !simple)
                    next_exc = `MCW_EXC_ILLEGAL_FUNCTION;
                else
                begin
                    next_config = req_wdata[7:0] & `MCW_CFG_MASK;
                    // leaving simple mode stops the watchdog
                    if (simple && !req_wdata[`MCW_CFG_SIMPLE] && state != ST_UNSET)
                        next_state = ST_STOPPED;
                    else if (!simple && req_wdata[`MCW_CFG_SIMPLE] && state == ST_STOPPED)
                    begin
                        next_state = ST_RUNNING;
                        next_reload = 1'b1;
                    end
                end
            end
        end
        // any other address handed to this block
        else if (acc_bad)
            next_exc = `MCW_EXC_ILLEGAL_ADDRESS;
        // a trigger restarts the timer; in simple mode it also revives an expired watchdog
        if (trig && next_state == ST_RUNNING)
            next_reload = 1'b1;
        if (trig && simple && state == ST_EXPIRED && next_state == ST_EXPIRED)
        begin
            next_state = ST_RUNNING;
            next_reload = 1'b1;
        end
        // expiry only when nothing else happens this cycle,
        // so a trigger and the last tick in one cycle keep the watchdog running
        if (state == ST_RUNNING && next_state == ST_RUNNING && !next_reload
            && tick && remain <= 16'h0001)
            next_state = ST_EXPIRED;
    end

    // ----------------------------------------------------------------
    // millisecond tick and countdown
    // ----------------------------------------------------------------
    // free running 1 ms tick; a trigger gives up to one tick of slack
    // the counter covers the default period with room; a far longer one needs more bits
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 25'h0000000;
            tick <= 1'b0;
        end
        else if (tick_cnt == TICK_CYCLES - 1)
        begin
            tick_cnt <= 25'h0000000;
            tick <= 1'b1;
        end
        else
        begin
            tick_cnt <= tick_cnt + 25'h0000001;
            tick <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // state, registers and outputs
    // ----------------------------------------------------------------
    // watchdog state and the two writable registers
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_UNSET;
            wd_timeout_ms <= `MCW_TIMEOUT_RESET;
            wd_config <= `MCW_CFG_RESET;
        end
        else
        begin
            state <= next_state;
            wd_timeout_ms <= next_timeout;
            wd_config <= next_config;
        end
    end

    // countdown in milliseconds; it holds its value outside the running state
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            remain <= 16'h0000;
        else if (next_reload)
            remain <= next_timeout;
        else if (state == ST_RUNNING && tick && remain != 16'h0000)
            remain <= remain - 16'h0001;
    end

    // answer to the register access, one cycle after the request
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            rsp_valid <= 1'b0;
            rsp_rdata <= 16'h0000;
            rsp_exception <= `MCW_EXC_NONE;
        end
        else
        begin
            rsp_valid <= req_valid;
            // a refused access returns no data, so a write-only register never reads back
            rsp_rdata <= (next_exc == `MCW_EXC_NONE) ? next_rdata : 16'h0000;
            rsp_exception <= next_exc;
        end
    end

    // one cycle pulse on entry to expired, for the slave to close its connections
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            drop_links_on_expiry <= 1'b0;
        else
            drop_links_on_expiry <= (state == ST_RUNNING) && (next_state == ST_EXPIRED)
                && wd_config[`MCW_CFG_DROP_LINKS];
    end

    // status code, taken from the next state so it never lags the state register
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
            wd_state_out <= `MCW_ST_UNSET;
        else
        begin
            case (next_state)
                ST_STOPPED: wd_state_out <= `MCW_ST_STOPPED;
                ST_RUNNING: wd_state_out <= `MCW_ST_RUNNING;
                ST_EXPIRED: wd_state_out <= `MCW_ST_EXPIRED;
                default: wd_state_out <= `MCW_ST_UNSET;
            endcase
        end
    end

endmodule // mcw_watchdog

// ==== verif/mcw_watchdog_sva.sv ====
// port checker for the modbus communication watchdog
`timescale 1ns/1ps
module mcw_sva (
    // clock and reset
    input wire clk,
    input wire arst_n,
    // request side
    input wire req_valid,
    input wire req_write,
    input wire [15:0] req_addr,
    input wire [15:0] req_wdata,
    input wire other_req,
    // answer and state
    input wire rsp_valid,
    input wire [15:0] rsp_rdata,
    input wire [7:0] rsp_exception,
    input wire drop_links_on_expiry,
    input wire [15:0] wd_state_out
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);
    wire rd = req_valid && !req_write;
    wire wr = req_valid && req_write;
    // a command write; its answer comes on the next edge
    sequence cmd(c);
        wr && req_addr == 16'hFA00 && req_wdata == c;
    endsequence
    cmd_no_read_a: assert property (
        rd && req_addr == 16'hFA00 |=> rsp_valid && rsp_exception == 8'h01) else $error("cmd read");
    state_read_a: assert property (
        rd && req_addr == 16'hFA02 |=> rsp_rdata == $past(wd_state_out)) else $error("state read");
    timeout_lock_a: assert property (
        wr && req_addr == 16'hFA01 && wd_state_out inside {16'h0001, 16'h0002}
        |=> rsp_exception == 8'h01) else $error("timeout write taken");
    unset_start_a: assert property (
        cmd(16'h5555) ##0 wd_state_out == 16'hFFFF |=> rsp_exception == 8'h03)
        else $error("start while unset");
    reset_refuse_a: assert property (
        cmd(16'hAAAA) ##0 wd_state_out != 16'h0002 |=> rsp_exception == 8'h03)
        else $error("reset taken");
    stop_repeat_a: assert property (
        cmd(16'h55AA) ##0 wd_state_out == 16'h0000 |=> rsp_exception == 8'h00
        && wd_state_out == 16'h0000) else $error("repeated stop");
    leave_unset_a: assert property (
        $past(wd_state_out) == 16'hFFFF && wd_state_out != 16'hFFFF
        |-> $past(wr && req_addr == 16'hFA01 && req_wdata != 16'h0000)) else $error("left unset");
    drop_entry_a: assert property (
        drop_links_on_expiry |-> wd_state_out == 16'h0002 && $past(wd_state_out) == 16'h0001)
        else $error("stray drop");
endmodule // mcw_sva

// ==== verif/mcw_master.sv ====
// modbus master model: register accesses and other traffic
`timescale 1ns/1ps
module mcw_master (
    // clock
    input wire clk,
    // requests toward the watchdog
    output logic req_valid,
    output logic req_write,
    output logic [15:0] req_addr,
    output logic [15:0] req_wdata,
    output logic other_req
);
    initial
    begin
        {req_valid, req_write, req_addr, req_wdata, other_req} <= '0;
    end
    // one access; the idle bus shows the inverse so stale values never match
    task send(input logic w, input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        req_valid <= 1'b1;
        req_write <= w;
        req_addr <= a;
        req_wdata <= d;
        @(posedge clk);
        req_valid <= 1'b0;
        req_write <= ~w;
        req_addr <= ~a;
        req_wdata <= ~d;
    endtask
    // any other valid request, one cycle
    task ping;
        @(posedge clk);
        other_req <= 1'b1;
        @(posedge clk);
        other_req <= 1'b0;
    endtask
endmodule // mcw_master

// ==== verif/tb.sv ====
// self-checking bench for the modbus communication watchdog
`timescale 1ns/1ps
module tb;
    logic clk = 0;
    logic arst_n = 0;
    logic req_valid, req_write, other_req;
    logic [15:0] req_addr, req_wdata;
    wire rsp_valid, drop_links_on_expiry;
    wire [15:0] rsp_rdata, wd_state_out;
    wire [7:0] rsp_exception;
    logic [24:0] q[$];
    logic [24:0] e;
    logic [31:0] seed = 32'h42C6;
    logic [31:0] r;
    int fail_count = 0;
    int samples_checked = 0;
    int drops = 0;
    int cycles = 0;
    int n, c;
    initial
    begin
        forever #20 clk = ~clk;
    end
    mcw_master master (.clk(clk), .req_valid(req_valid), .req_write(req_write),
        .req_addr(req_addr), .req_wdata(req_wdata), .other_req(other_req));
    // short tick so a few milliseconds fit in a short run
    mcw_watchdog #(.TICK_CYCLES(10)) DUT (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
        .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
        .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_exception(rsp_exception),
        .other_req(other_req), .drop_links_on_expiry(drop_links_on_expiry),
        .wd_state_out(wd_state_out));
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task stop_test;
        if (fail_count == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // note {is read, exception, read data} for the monitor
    task acc(input logic w, input logic [15:0] a, input logic [15:0] d, input logic [7:0] x);
        master.send(w, a, d);
        q.push_back({~w, x, d});
    endtask
    task st(input logic [15:0] x);
        #1 check("state", wd_state_out, x);
    endtask
    // k pings, fixed gap g, or a random gap below the timeout when g is 0
    task pings(input int k, input int g);
        repeat (k)
        begin
            repeat (g > 0 ? g : rnd() % 30) @(posedge clk);
            master.ping();
        end
    endtask
    task expire;
        c = 0;
        while (wd_state_out !== 16'h0002 && c < 200)
        begin
            @(posedge clk);
            #1 c++;
        end
    endtask
    // answers matched in order; also the hang limit and drop count
    always @(posedge clk)
    begin
        cycles++;
        if (drop_links_on_expiry === 1'b1)
            drops++;
        if (rsp_valid === 1'b1)
        begin
            e = (q.size() > 0) ? q.pop_front() : 25'h1FFFFFF;
            check("exception", {8'h00, rsp_exception}, {8'h00, e[23:16]});
            if (e[24])
                check("rdata", rsp_rdata, e[15:0]);
        end
        if (cycles == 5000)
        begin
            fail_count++;
            stop_test;
        end
    end
    initial
    begin
        repeat (5) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        acc(0, 16'hFA02, 16'hFFFF, 8'h00);
        acc(0, 16'hFA01, 16'h0000, 8'h00);
        acc(0, 16'hFA03, 16'h0004, 8'h00);
        acc(0, 16'hFA00, 16'h0000, 8'h01);
        acc(0, 16'hFA05, 16'h0000, 8'h02);
        acc(1, 16'hFA00, 16'h5555, 8'h03);
        acc(1, 16'hFA00, 16'h55AA, 8'h03);
        acc(1, 16'hFA00, 16'hAAAA, 8'h03);
        acc(1, 16'hFA02, 16'h0000, 8'h01);
        acc(1, 16'hFA01, 16'h0005, 8'h00);
        st(16'h0000);
        acc(1, 16'hFA00, 16'h55AA, 8'h00);
        acc(1, 16'hFA00, 16'h55AA, 8'h00);
        acc(1, 16'hFA00, 16'h5555, 8'h00);
        st(16'h0001);
        acc(1, 16'hFA01, 16'h0009, 8'h01);
        acc(0, 16'hFA01, 16'h0005, 8'h00);
        pings(8, 0);
        st(16'h0001);
        n = drops;
        expire;
        // 5 ms of 10-cycle ticks, at most one tick early
        check("expiry", 16'(c >= 40 && c <= 50), 16'h0001);
        @(posedge clk);
        #1 check("drops", 16'(drops - n), 16'h0001);
        acc(1, 16'hFA00, 16'h5555, 8'h03);
        acc(1, 16'hFA00, 16'h55AA, 8'h03);
        acc(1, 16'hFA00, 16'hAAAA, 8'h00);
        st(16'h0000);
        // explicit trigger without link drop: pings must not hold it off
        acc(1, 16'hFA03, 16'h0001, 8'h00);
        acc(1, 16'hFA00, 16'h5555, 8'h00);
        n = drops;
        pings(4, 15);
        st(16'h0002);
        check("drops", 16'(drops - n), 16'h0000);
        acc(1, 16'hFA00, 16'hAAAA, 8'h00);
        // status reads as the only trigger
        acc(1, 16'hFA03, 16'h0002, 8'h00);
        acc(1, 16'hFA00, 16'h5555, 8'h00);
        repeat (6)
        begin
            repeat (15) @(posedge clk);
            acc(0, 16'hFA02, 16'h0001, 8'h00);
        end
        acc(1, 16'hFA00, 16'h55AA, 8'h00);
        // simple mode arms itself and only a return to advanced stops it
        acc(1, 16'hFA03, 16'h0084, 8'h00);
        st(16'h0001);
        acc(1, 16'hFA00, 16'h55AA, 8'h03);
        acc(1, 16'hFA00, 16'hAAAA, 8'h03);
        // any other code is refused; the top nibble keeps it off the three command codes
        r = rnd();
        acc(1, 16'hFA00, {4'h1, r[11:0]}, 8'h03);
        expire;
        st(16'h0002);
        master.ping();
        st(16'h0001);
        acc(1, 16'hFA00, 16'h5555, 8'h00);
        st(16'h0001);
        acc(1, 16'hFA03, 16'h0004, 8'h00);
        st(16'h0000);
        repeat (2) @(posedge clk);
        check("pending", 16'(q.size()), 16'h0000);
        stop_test;
    end
endmodule // tb
bind mcw_watchdog mcw_sva checker_i (.clk(clk), .arst_n(arst_n), .req_valid(req_valid),
    .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata), .other_req(other_req),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_exception(rsp_exception),
    .drop_links_on_expiry(drop_links_on_expiry), .wd_state_out(wd_state_out));
